// >>> hw/lru_pkg.sv
package lru_pkg;

  // ----------------------------------------------------------------
  // Widths, timing and instruction shape
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;
  localparam int MC_CLKS = 12;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic CARRY_RST = 1'b0;
  localparam logic [2:0] BANK_PAD = 3'h0;
  localparam logic [1:0] PTR_PAD = 2'h0;

  // ----------------------------------------------------------------
  // Operations, operand sources and destinations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_AND_LOGICAL, OP_OR_LOGICAL, OP_EXCLUSIVE_OR_LOGICAL,
    OP_CLEAR_ACCUMULATOR, OP_COMPLEMENT_ACCUMULATOR,
    OP_ROTATE_LEFT, OP_ROTATE_LEFT_THROUGH_CARRY,
    OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_THROUGH_CARRY
  } lru_op_t;

  typedef enum logic [2:0] {
    SRC_WORKING_REGISTER, SRC_DIRECT, SRC_INDIRECT_POINTER,
    SRC_IMMEDIATE, SRC_ACCUMULATOR
  } lru_src_t;

  typedef enum logic {DST_ACCUMULATOR, DST_DIRECT} lru_dst_t;

  typedef enum logic [2:0] {S_IDLE, S_RD_PTR, S_PTR, S_RD_OPND, S_EXEC, S_WAIT} lru_fsm_t;

  typedef struct packed {
    lru_op_t op;
    lru_src_t src;
    lru_dst_t dst;
    logic [2:0] reg_idx;
    logic ptr_sel;
    logic [7:0] dir_addr;
    logic [7:0] imm;
  } lru_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lru_mem_t;

  typedef struct packed {
    lru_fsm_t state;
    lru_req_t req;
    logic [CNT_W-1:0] cnt;
    logic [7:0] acc;
    logic carry;
    lru_mem_t mem;
    logic busy;
    logic done;
    logic [1:0] bytes;
    logic [1:0] cycles;
  } lru_state_t;

endpackage

// >>> hw/lru_unit.sv
`timescale 1ns/1ps
module lru_unit
#(
  parameter int MC_CLKS = lru_pkg::MC_CLKS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire lru_pkg::lru_req_t req,
  input wire logic [1:0] reg_bank,
  input wire logic [7:0] mem_rdata,
  output lru_pkg::lru_mem_t mem,
  output logic [7:0] acc,
  output logic carry,
  output logic busy,
  output logic done,
  output logic [1:0] instr_bytes,
  output logic [1:0] instr_cycles
);
  import lru_pkg::*;

  // ----------------------------------------------------------------
  // Instruction shape
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] ONE_MC = CNT_W'(MC_CLKS);
  localparam logic [CNT_W-1:0] TWO_MC = CNT_W'(2 * MC_CLKS);

  function automatic logic [1:0] len_of(input lru_req_t r);
    logic [1:0] n;
    n = LEN_ONE;
    if (r.dst == DST_DIRECT && r.src == SRC_IMMEDIATE)
    begin
      n = LEN_THREE;
    end
    else if (r.dst == DST_DIRECT || r.src == SRC_DIRECT || r.src == SRC_IMMEDIATE)
    begin
      n = LEN_TWO;
    end
    return n;
  endfunction

  function automatic logic [1:0] cyc_of(input lru_req_t r);
    logic [1:0] n;
    n = CYC_ONE;
    if (r.dst == DST_DIRECT && r.src == SRC_IMMEDIATE)
    begin
      n = CYC_TWO;
    end
    return n;
  endfunction

  function automatic logic [CNT_W-1:0] clks_of(input logic [1:0] c);
    return (c == CYC_TWO) ? TWO_MC : ONE_MC;
  endfunction

  function automatic logic is_logic_op(input lru_op_t op);
    return op == OP_AND_LOGICAL || op == OP_OR_LOGICAL || op == OP_EXCLUSIVE_OR_LOGICAL;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lru_state_t st;
  lru_state_t next_st;
  logic [7:0] a_val;
  logic [7:0] b_val;
  logic [7:0] res;
  logic [7:0] wreg_base;

  assign mem = st.mem;
  assign acc = st.acc;
  assign carry = st.carry;
  assign busy = st.busy;
  assign done = st.done;
  assign instr_bytes = st.bytes;
  assign instr_cycles = st.cycles;

  // Working registers sit in the bank selected by the core.
  assign wreg_base = {BANK_PAD, reg_bank, 3'h0};

  // ----------------------------------------------------------------
  // Operand selection and combine
  // ----------------------------------------------------------------
  // A direct destination combines the byte just read with the
  // accumulator or the immediate; otherwise the accumulator is the
  // first operand.
  always_comb
  begin
    if (st.req.dst == DST_DIRECT)
    begin
      a_val = mem_rdata;
      b_val = (st.req.src == SRC_IMMEDIATE) ? st.req.imm : st.acc;
    end
    else
    begin
      a_val = st.acc;
      if (st.req.src == SRC_IMMEDIATE)
      begin
        b_val = st.req.imm;
      end
      else if (st.req.src == SRC_ACCUMULATOR)
      begin
        b_val = st.acc;
      end
      else
      begin
        b_val = mem_rdata;
      end
    end
    case (st.req.op)
      OP_AND_LOGICAL: res = a_val & b_val;
      OP_OR_LOGICAL: res = a_val | b_val;
      OP_EXCLUSIVE_OR_LOGICAL: res = a_val ^ b_val;
      default: res = a_val;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.mem.rd = 1'b0;
    next_st.mem.wr = 1'b0;
    next_st.done = 1'b0;
    if (st.state != S_IDLE)
    begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
    case (st.state)
      S_IDLE:
      begin
        if (start)
        begin
          next_st.req = req;
          next_st.cnt = CNT_W'(1);
          next_st.bytes = len_of(req);
          next_st.cycles = cyc_of(req);
          if (!is_logic_op(req.op) || (req.dst == DST_ACCUMULATOR
              && (req.src == SRC_IMMEDIATE || req.src == SRC_ACCUMULATOR)))
          begin
            next_st.state = S_EXEC;
          end
          else if (req.dst == DST_DIRECT || req.src == SRC_DIRECT)
          begin
            next_st.state = S_RD_OPND;
            next_st.mem.rd = 1'b1;
            next_st.mem.addr = req.dir_addr;
          end
          else if (req.src == SRC_INDIRECT_POINTER)
          begin
            next_st.state = S_RD_PTR;
            next_st.mem.rd = 1'b1;
            next_st.mem.addr = wreg_base | {5'h00, PTR_PAD, req.ptr_sel};
          end
          else
          begin
            next_st.state = S_RD_OPND;
            next_st.mem.rd = 1'b1;
            next_st.mem.addr = wreg_base | {5'h00, req.reg_idx};
          end
        end
      end
      S_RD_PTR:
      begin
        next_st.state = S_PTR;
      end
      S_PTR:
      begin
        // The pointer byte names the internal data location to read.
        next_st.state = S_RD_OPND;
        next_st.mem.rd = 1'b1;
        next_st.mem.addr = mem_rdata;
      end
      S_RD_OPND:
      begin
        next_st.state = S_EXEC;
      end
      S_EXEC:
      begin
        next_st.state = S_WAIT;
        case (st.req.op)
          OP_CLEAR_ACCUMULATOR: next_st.acc = 8'h00;
          OP_COMPLEMENT_ACCUMULATOR: next_st.acc = ~st.acc;
          OP_ROTATE_LEFT: next_st.acc = {st.acc[6:0], st.acc[7]};
          OP_ROTATE_RIGHT: next_st.acc = {st.acc[0], st.acc[7:1]};
          OP_ROTATE_LEFT_THROUGH_CARRY:
          begin
            next_st.acc = {st.acc[6:0], st.carry};
            next_st.carry = st.acc[7];
          end
          OP_ROTATE_RIGHT_THROUGH_CARRY:
          begin
            next_st.acc = {st.carry, st.acc[7:1]};
            next_st.carry = st.acc[0];
          end
          default:
          begin
            // Logic operations never touch the carry flag.
            if (st.req.dst == DST_DIRECT)
            begin
              next_st.mem.wr = 1'b1;
              next_st.mem.addr = st.req.dir_addr;
              next_st.mem.wdata = res;
            end
            else
            begin
              next_st.acc = res;
            end
          end
        endcase
      end
      S_WAIT:
      begin
        // Holding here pads the instruction out to whole machine cycles.
        if (st.cnt >= clks_of(st.cycles) - CNT_W'(1))
        begin
          next_st.state = S_IDLE;
          next_st.done = 1'b1;
        end
      end
      default:
      begin
        next_st.state = S_IDLE;
      end
    endcase
    next_st.busy = next_st.state != S_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.state <= S_IDLE;
      st.acc <= ACC_RST;
      st.carry <= CARRY_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_and_to_acc: assert property (
    (st.state == S_EXEC && st.req.op == OP_AND_LOGICAL && st.req.dst == DST_ACCUMULATOR)
    |=> acc == ($past(st.acc) & $past(b_val)))
    else $error("AND result not in accumulator");

  a_or_to_acc: assert property (
    (st.state == S_EXEC && st.req.op == OP_OR_LOGICAL && st.req.dst == DST_ACCUMULATOR)
    |=> acc == ($past(st.acc) | $past(b_val)))
    else $error("OR result not in accumulator");

  a_xor_to_dir: assert property (
    (st.state == S_EXEC && st.req.op == OP_EXCLUSIVE_OR_LOGICAL
     && st.req.dst == DST_DIRECT)
    |=> mem.wr && mem.wdata == ($past(mem_rdata) ^ $past(b_val))
        && mem.addr == $past(st.req.dir_addr))
    else $error("exclusive-OR write-back wrong");

  a_and_to_dir: assert property (
    (st.state == S_EXEC && st.req.op == OP_AND_LOGICAL && st.req.dst == DST_DIRECT)
    |=> mem.wr ##1 !mem.wr)
    else $error("AND write-back not a single strobe");

  a_two_cycle_form: assert property (
    (st.state == S_IDLE && start && req.dst == DST_DIRECT && req.src == SRC_IMMEDIATE)
    |=> instr_cycles == CYC_TWO && instr_bytes == LEN_THREE && busy)
    else $error("immediate-to-direct shape wrong");

  a_done_time: assert property (
    done |-> ($past(st.cnt) + CNT_W'(1)) == clks_of(instr_cycles))
    else $error("instruction time wrong");

  a_wr_in_time: assert property (
    mem.wr |-> busy && st.cnt < clks_of(st.cycles))
    else $error("write-back outside instruction");

  a_clr_zero: assert property (
    (st.state == S_EXEC && st.req.op == OP_CLEAR_ACCUMULATOR)
    |=> acc == 8'h00 ##1 acc == 8'h00)
    else $error("clear did not zero accumulator");

  a_rlc_carry: assert property (
    (st.state == S_EXEC && st.req.op == OP_ROTATE_LEFT_THROUGH_CARRY)
    |=> carry == $past(st.acc[7]) && acc[0] == $past(st.carry))
    else $error("left rotate through carry wrong");

  a_rrc_carry: assert property (
    (st.state == S_EXEC && st.req.op == OP_ROTATE_RIGHT_THROUGH_CARRY)
    |=> carry == $past(st.acc[0]) && acc[7] == $past(st.carry))
    else $error("right rotate through carry wrong");

  a_plain_rot: assert property (
    (st.state == S_EXEC && (st.req.op == OP_ROTATE_LEFT || st.req.op == OP_ROTATE_RIGHT))
    |=> carry == $past(st.carry) && (st.req.op == OP_ROTATE_LEFT
        ? acc == {$past(st.acc[6:0]), $past(st.acc[7])}
        : acc == {$past(st.acc[0]), $past(st.acc[7:1])}))
    else $error("plain rotate disturbed carry");

  a_logic_carry: assert property (
    (st.state == S_EXEC && is_logic_op(st.req.op)) |=> $stable(carry))
    else $error("logic operation changed carry");

  a_ind_pointer: assert property (
    st.state == S_PTR |=> mem.rd && mem.addr == $past(mem_rdata))
    else $error("indirect address not taken from pointer");

endmodule

// >>> testbench/logical_rotate_instruction_unit_bench.sv
`timescale 1ns/1ps
module logical_rotate_instruction_unit_bench;
  import lru_pkg::*;
  localparam int MC = 6;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  lru_req_t req = '0;
  logic [1:0] reg_bank = 2'h0;
  logic [7:0] mem_rdata = 8'h00;
  lru_mem_t mem;
  logic [7:0] acc;
  logic carry, busy, done;
  logic [1:0] instr_bytes, instr_cycles;
  logic [7:0] arr [256];
  lru_mem_t mem_q = '0;
  int miscompares = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  lru_unit #(.MC_CLKS(MC)) uut (.clk(clk), .sys_rst(sys_rst), .start(start), .req(req),
    .reg_bank(reg_bank), .mem_rdata(mem_rdata), .mem(mem), .acc(acc), .carry(carry),
    .busy(busy), .done(done), .instr_bytes(instr_bytes), .instr_cycles(instr_cycles));

  // ------------------------------------------------------------
  // Synchronous memory: data only in the cycle after a read strobe.
  // ------------------------------------------------------------
  always @(negedge clk) mem_q = mem;
  always @(posedge clk)
  begin
    #1;
    if (mem_q.wr === 1'b1) arr[mem_q.addr] = mem_q.wdata;
    // Outside a read cycle the bus shows junk so stale data is never trusted.
    if (mem_q.rd === 1'b1) mem_rdata = arr[mem_q.addr];
    else mem_rdata = ~mem_rdata;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One instruction: issue, time the completion, judge accumulator, carry, bytes and cycles.
  task automatic op(input lru_op_t o, input lru_src_t s, input lru_dst_t d,
    input logic [7:0] a, input logic [7:0] im, input logic [7:0] ea, input logic ec,
    input logic [1:0] eb, input logic [1:0] ey);
    int n;
    req = '{o, s, d, a[2:0], a[0], a, im};
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    n = 1;
    chk({7'h0, busy}, 8'h01);
    while (done !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 100)
    begin
      miscompares++;
      $display("wrong value at %0t: no completion", $time);
      finish_test();
    end
    chk(8'(n), 8'(ey * MC));
    chk({7'h0, busy}, 8'h00);
    chk(acc, ea);
    chk({7'h0, carry}, {7'h0, ec});
    chk({6'h0, instr_bytes}, {6'h0, eb});
    chk({6'h0, instr_cycles}, {6'h0, ey});
  endtask

  task automatic t_logic();
    op(OP_CLEAR_ACCUMULATOR, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 0, 0, 1, 1);
    op(OP_OR_LOGICAL, SRC_IMMEDIATE, DST_ACCUMULATOR, 0, 8'ha5, 8'ha5, 0, 2, 1);
    op(OP_AND_LOGICAL, SRC_IMMEDIATE, DST_ACCUMULATOR, 0, 8'h3c, 8'h24, 0, 2, 1);
    op(OP_EXCLUSIVE_OR_LOGICAL, SRC_IMMEDIATE, DST_ACCUMULATOR, 0, 8'hff, 8'hdb, 0, 2, 1);
    op(OP_COMPLEMENT_ACCUMULATOR, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 8'h24, 0, 1, 1);
  endtask

  task automatic t_rotate();
    op(OP_OR_LOGICAL, SRC_IMMEDIATE, DST_ACCUMULATOR, 0, 8'h81, 8'ha5, 0, 2, 1);
    op(OP_AND_LOGICAL, SRC_IMMEDIATE, DST_ACCUMULATOR, 0, 8'h81, 8'h81, 0, 2, 1);
    op(OP_ROTATE_LEFT, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 8'h03, 0, 1, 1);
    op(OP_ROTATE_RIGHT, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 8'h81, 0, 1, 1);
    op(OP_ROTATE_LEFT_THROUGH_CARRY, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 8'h02, 1, 1, 1);
    op(OP_AND_LOGICAL, SRC_IMMEDIATE, DST_ACCUMULATOR, 0, 8'hff, 8'h02, 1, 2, 1);
    op(OP_ROTATE_RIGHT_THROUGH_CARRY, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 8'h81, 0, 1, 1);
    op(OP_ROTATE_RIGHT_THROUGH_CARRY, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 8'h40, 1, 1, 1);
    op(OP_ROTATE_LEFT_THROUGH_CARRY, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 8'h81, 0, 1, 1);
    op(OP_ROTATE_LEFT_THROUGH_CARRY, SRC_ACCUMULATOR, DST_ACCUMULATOR, 0, 0, 8'h02, 1, 1, 1);
  endtask

  task automatic t_memory();
    reg_bank = 2'h2;
    arr[8'h15] = 8'h0f;
    arr[8'h11] = 8'h40;
    arr[8'h40] = 8'hf0;
    arr[8'h90] = 8'h55;
    arr[8'h30] = 8'h3c;
    arr[8'ha0] = 8'h12;
    op(OP_OR_LOGICAL, SRC_IMMEDIATE, DST_ACCUMULATOR, 0, 8'hff, 8'hff, 1, 2, 1);
    op(OP_AND_LOGICAL, SRC_WORKING_REGISTER, DST_ACCUMULATOR, 5, 0, 8'h0f, 1, 1, 1);
    op(OP_OR_LOGICAL, SRC_INDIRECT_POINTER, DST_ACCUMULATOR, 1, 0, 8'hff, 1, 1, 1);
    op(OP_EXCLUSIVE_OR_LOGICAL, SRC_DIRECT, DST_ACCUMULATOR, 8'h90, 0, 8'haa, 1, 2, 1);
    op(OP_AND_LOGICAL, SRC_ACCUMULATOR, DST_DIRECT, 8'h30, 0, 8'haa, 1, 2, 1);
    chk(arr[8'h30], 8'h28);
    op(OP_OR_LOGICAL, SRC_IMMEDIATE, DST_DIRECT, 8'ha0, 8'h0f, 8'haa, 1, 3, 2);
    chk(arr[8'ha0], 8'h1f);
    op(OP_EXCLUSIVE_OR_LOGICAL, SRC_ACCUMULATOR, DST_DIRECT, 8'h30, 0, 8'haa, 1, 2, 1);
    chk(arr[8'h30], 8'h82);
    op(OP_AND_LOGICAL, SRC_IMMEDIATE, DST_DIRECT, 8'ha0, 8'h33, 8'haa, 1, 3, 2);
    chk(arr[8'ha0], 8'h13);
    op(OP_EXCLUSIVE_OR_LOGICAL, SRC_IMMEDIATE, DST_DIRECT, 8'h30, 8'hff, 8'haa, 1, 3, 2);
    chk(arr[8'h30], 8'h7d);
    op(OP_OR_LOGICAL, SRC_ACCUMULATOR, DST_DIRECT, 8'ha0, 0, 8'haa, 1, 2, 1);
    chk(arr[8'ha0], 8'hbb);
  endtask

  // A start while busy must be ignored: one completion, first result only.
  task automatic t_busy();
    logic seen;
    req = '{OP_CLEAR_ACCUMULATOR, SRC_ACCUMULATOR, DST_ACCUMULATOR, 3'h0, 1'b0, 8'h0, 8'h0};
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    @(posedge clk);
    #1 req.op = OP_COMPLEMENT_ACCUMULATOR;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    seen = 1'b0;
    repeat (3 * MC)
    begin
      @(posedge clk);
      #1 if (done === 1'b1) seen = ~seen;
    end
    chk({7'h0, seen}, 8'h01);
    chk(acc, 8'h00);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(acc, 8'h00);
    t_logic();
    t_rotate();
    t_memory();
    t_busy();
    finish_test();
  end
endmodule
